//--- logic/setpoint_defines.svh
`ifndef SETPOINT_DEFINES_SVH
`define SETPOINT_DEFINES_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_POT_CFG 8'h04
`define REG_START_VALUE 8'h08
`define REG_RAMP_UP 8'h0C
`define REG_RAMP_DOWN 8'h10
`define REG_MAX_SPEED 8'h14
`define REG_MIN_SPEED 8'h18
`define REG_SET_VALUE 8'h1C
`define REG_POT_OUT 8'h20
`define REG_MAIN_OUT 8'h24
`define REG_SUPP_OUT 8'h28
`define REG_STORED 8'h2C
// control register fields
`define CTRL_MAIN_SEL_LSB 0
`define CTRL_SUPP_SEL_LSB 4
`define CTRL_RAISE_BIT 8
`define CTRL_LOWER_BIT 9
`define CTRL_MOTOR_ON_BIT 10
`define CTRL_INVERT_BIT 11
`define CTRL_AUTO_BIT 12
`define CTRL_ACCEPT_BIT 13
`define CTRL_OVERRIDE_BIT 14
// pot configuration bits
`define CFG_STORE_BIT 0
`define CFG_AUTO_RAMP_BIT 1
`define CFG_ROUND_BIT 2
`define CFG_NVRAM_BIT 3
`define CFG_ALWAYS_BIT 4
`define CFG_RESET 5'h06
// reset values, rpm and ms
`define START_VALUE_RESET 16'h0000
`define RAMP_TIME_RESET_MS 32'h00002710
`define SPEED_LIMIT_RESET 16'h0000
// timing: one millisecond at 250 MHz
`define CLK_MHZ 250
`define MS_CYCLES (`CLK_MHZ * 1000)
// rpm full range reached in ramp time (pot scale)
`define RPM_FULL 16'h7FFF
`endif

//--- logic/setpoint_pkg.sv
`default_nettype none
package setpoint_pkg;
   typedef enum logic [1:0] {
      SRC_ANALOG = 2'h0,
      SRC_FIELDBUS = 2'h1,
      SRC_POT = 2'h3,
      SRC_FIXED = 2'h2
   } source_e;
   typedef struct packed {
      logic raise;
      logic lower;
      logic motor_on;
      logic invert;
      logic auto_mode;
      logic accept;
      logic override;
   } pot_cmd_s;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_RUN = 2'b01,
      ST_HOLD = 2'b11
   } pot_state_e;
endpackage
`default_nettype wire

//--- logic/speed_setpoint_source.sv
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_defines.svh"
module speed_setpoint_source #(
   parameter int MS_CYC = `MS_CYCLES
) (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, active low
   input wire logic [15:0] analog_in0, // analog input 0 value
   input wire logic [15:0] fieldbus_pzd2, // second process data word
   input wire logic [15:0] fixed_setpoint, // fixed setpoint value
   input wire logic [15:0] override_setpoint, // replacement setpoint
   input wire logic [15:0] nv_value_in, // non-volatile stored value
   output logic nv_write, // pulse: store value to nvram
   output logic [15:0] nv_value_out, // value to store
   output logic [15:0] main_setpoint, // selected main setpoint
   output logic [15:0] supp_setpoint, // selected supplementary setpoint
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready // read ready
);
   // the ramp divider needs at least one cycle per millisecond
   if (MS_CYC < 1) begin
      $error("MS_CYC must be at least one");
   end

   logic [31:0] ctrl_r;
   logic [4:0] cfg_r;
   logic [15:0] start_r, maxs_r, mins_r, setv_r;
   logic [31:0] up_ms_r, dn_ms_r;
   logic aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r, rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] bresp_r, rresp_r;

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready = !w_got_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire aw_have = aw_got_r || aw_hs;
   wire w_have = w_got_r || w_hs;
   wire [7:0] wa = aw_got_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wd = w_got_r ? wdata_r : s_axi_wdata;
   wire [3:0] ws = w_got_r ? wstrb_r : s_axi_wstrb;
   wire do_wr = aw_have && w_have && !bvalid_r;
   // byte lane enables from the write strobes
   wire [31:0] wmask;
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{ws[b]}};
   end
   wire wr_ctrl = do_wr && (wa == `REG_CTRL);
   wire wr_cfg = do_wr && (wa == `REG_POT_CFG);
   wire wr_start = do_wr && (wa == `REG_START_VALUE);
   wire wr_up = do_wr && (wa == `REG_RAMP_UP);
   wire wr_dn = do_wr && (wa == `REG_RAMP_DOWN);
   wire wr_max = do_wr && (wa == `REG_MAX_SPEED);
   wire wr_min = do_wr && (wa == `REG_MIN_SPEED);
   wire wr_setv = do_wr && (wa == `REG_SET_VALUE);
   wire wr_ro = (wa == `REG_POT_OUT) || (wa == `REG_MAIN_OUT) ||
      (wa == `REG_SUPP_OUT) || (wa == `REG_STORED);
   wire wr_ok = wr_ctrl || wr_cfg || wr_start || wr_up || wr_dn || wr_max ||
      wr_min || wr_setv || wr_ro;

   function automatic [31:0] merge(input [31:0] old, input [31:0] nw, input [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
      end else begin
         if (aw_hs) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? 2'h0 : 2'h2;
         end else begin
            aw_got_r <= aw_have;
            w_got_r <= w_have;
            if (s_axi_bready) begin
               bvalid_r <= 1'b0;
            end
         end
      end
   end

   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= 32'h00000000;
         cfg_r <= `CFG_RESET;
         start_r <= `START_VALUE_RESET;
         up_ms_r <= `RAMP_TIME_RESET_MS;
         dn_ms_r <= `RAMP_TIME_RESET_MS;
         maxs_r <= `SPEED_LIMIT_RESET;
         mins_r <= `SPEED_LIMIT_RESET;
         setv_r <= 16'h0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= merge(ctrl_r, wd, wmask);
         end
         if (wr_cfg) begin
            cfg_r <= 5'(merge({27'h0, cfg_r}, wd, wmask));
         end
         if (wr_start) begin
            start_r <= 16'(merge({16'h0, start_r}, wd, wmask));
         end
         if (wr_up) begin
            up_ms_r <= merge(up_ms_r, wd, wmask);
         end
         if (wr_dn) begin
            dn_ms_r <= merge(dn_ms_r, wd, wmask);
         end
         if (wr_max) begin
            maxs_r <= 16'(merge({16'h0, maxs_r}, wd, wmask));
         end
         if (wr_min) begin
            mins_r <= 16'(merge({16'h0, mins_r}, wd, wmask));
         end
         if (wr_setv) begin
            setv_r <= 16'(merge({16'h0, setv_r}, wd, wmask));
         end
      end
   end

   setpoint_pkg::pot_cmd_s cmd;
   // one assignment, so the command struct has a single driver
   assign cmd = {
      ctrl_r[`CTRL_RAISE_BIT],
      ctrl_r[`CTRL_LOWER_BIT],
      ctrl_r[`CTRL_MOTOR_ON_BIT],
      ctrl_r[`CTRL_INVERT_BIT],
      ctrl_r[`CTRL_AUTO_BIT],
      ctrl_r[`CTRL_ACCEPT_BIT],
      ctrl_r[`CTRL_OVERRIDE_BIT]
   };
   wire [1:0] main_sel = ctrl_r[`CTRL_MAIN_SEL_LSB +: 2];
   wire [1:0] supp_sel = ctrl_r[`CTRL_SUPP_SEL_LSB +: 2];

   // limits, signed rpm; inversion negates and swaps them
   wire signed [15:0] maxs = maxs_r;
   wire signed [15:0] mins = mins_r;
   wire signed [15:0] hi_lim = cmd.invert ? 16'(-mins) : maxs;
   wire signed [15:0] lo_lim = cmd.invert ? 16'(-maxs) : mins;
   wire signed [15:0] lim_hi = (hi_lim >= lo_lim) ? hi_lim : lo_lim;
   wire signed [15:0] lim_lo = (hi_lim >= lo_lim) ? lo_lim : hi_lim;

   setpoint_pkg::pot_state_e st_r;
   logic signed [15:0] pot_r, stored_r;
   logic [31:0] tick_r, tick_div_up, tick_div_dn;
   logic [3:0] round_r;
   logic accept_d_r, motor_d_r;

   // ramp: full range RPM_FULL in ramp time; one rpm step per period
   wire [47:0] up_prod = 48'(up_ms_r) * 48'(MS_CYC);
   wire [47:0] dn_prod = 48'(dn_ms_r) * 48'(MS_CYC);
   assign tick_div_up = 32'(up_prod / 48'(`RPM_FULL));
   assign tick_div_dn = 32'(dn_prod / 48'(`RPM_FULL));
   wire use_ramp = !cmd.auto_mode || cfg_r[`CFG_AUTO_RAMP_BIT];
   wire running = cmd.motor_on || cfg_r[`CFG_ALWAYS_BIT];
   wire up_req = cmd.raise && !cmd.lower;
   wire dn_req = cmd.lower && !cmd.raise;
   wire [31:0] period = up_req ? tick_div_up : tick_div_dn;
   // initial rounding: first steps take longer, shortening as the move goes on
   wire [1:0] round_shift = 2'h3 - round_r[1:0];
   wire [31:0] eff_period = cfg_r[`CFG_ROUND_BIT] ? (period << round_shift) : period;
   wire tick = (tick_r + 32'h00000001 >= eff_period);
   wire accept_rise = cmd.accept && !accept_d_r;
   wire switch_on = cmd.motor_on && !motor_d_r;
   wire switch_off = !cmd.motor_on && motor_d_r;
   wire restore = cfg_r[`CFG_STORE_BIT];
   wire signed [15:0] restore_val = cfg_r[`CFG_NVRAM_BIT] ? nv_value_in : stored_r;

   function automatic signed [15:0] clamp(input signed [15:0] v,
         input signed [15:0] lo, input signed [15:0] hi);
      clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= setpoint_pkg::ST_OFF;
         pot_r <= 16'sh0000;
         stored_r <= 16'sh0000;
         tick_r <= 32'h00000000;
         round_r <= 4'h0;
         accept_d_r <= 1'b0;
         motor_d_r <= 1'b0;
         nv_write <= 1'b0;
         nv_value_out <= 16'h0000;
      end else begin
         accept_d_r <= cmd.accept;
         motor_d_r <= cmd.motor_on;
         nv_write <= 1'b0;
         // saved here even when run drops to off in the same cycle
         if (switch_off && restore) begin
            stored_r <= pot_r;
            nv_value_out <= pot_r;
            nv_write <= cfg_r[`CFG_NVRAM_BIT];
         end
         case (st_r)
            setpoint_pkg::ST_OFF: begin
               tick_r <= 32'h00000000;
               round_r <= 4'h0;
               if (switch_on) begin
                  pot_r <= clamp(restore ? restore_val : start_r, lim_lo, lim_hi);
                  st_r <= setpoint_pkg::ST_RUN;
               end else if (running) begin
                  st_r <= setpoint_pkg::ST_RUN;
               end
            end
            setpoint_pkg::ST_RUN: begin
               if (!running) begin
                  st_r <= setpoint_pkg::ST_OFF;
               end else if (accept_rise) begin
                  pot_r <= clamp(setv_r, lim_lo, lim_hi);
               end else if (switch_on) begin
                  pot_r <= clamp(restore ? restore_val : start_r, lim_lo, lim_hi);
               end else if (up_req || dn_req) begin
                  if (!use_ramp) begin
                     pot_r <= up_req ? lim_hi : lim_lo;
                  end else if (tick) begin
                     tick_r <= 32'h00000000;
                     if (round_r != 4'h3) begin
                        round_r <= round_r + 4'h1;
                     end
                     if (up_req && pot_r < lim_hi) begin
                        pot_r <= pot_r + 16'sh0001;
                     end else if (dn_req && pot_r > lim_lo) begin
                        pot_r <= pot_r - 16'sh0001;
                     end
                  end else begin
                     tick_r <= tick_r + 32'h00000001;
                  end
               end else begin
                  tick_r <= 32'h00000000;
                  round_r <= 4'h0;
                  pot_r <= clamp(pot_r, lim_lo, lim_hi);
                  if (cmd.raise && cmd.lower) begin
                     st_r <= setpoint_pkg::ST_HOLD;
                  end
               end
            end
            setpoint_pkg::ST_HOLD: begin
               // both commands: hold until one of them drops
               if (!running) begin
                  st_r <= setpoint_pkg::ST_OFF;
               end else if (!(cmd.raise && cmd.lower)) begin
                  st_r <= setpoint_pkg::ST_RUN;
               end
            end
            default: st_r <= setpoint_pkg::ST_OFF;
         endcase
      end
   end

   // source selection
   function automatic [15:0] pick(input [1:0] sel, input [15:0] pot);
      case (sel)
         setpoint_pkg::SRC_ANALOG: pick = analog_in0;
         setpoint_pkg::SRC_FIELDBUS: pick = fieldbus_pzd2;
         setpoint_pkg::SRC_POT: pick = pot;
         default: pick = fixed_setpoint;
      endcase
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_setpoint <= 16'h0000;
         supp_setpoint <= 16'h0000;
      end else begin
         main_setpoint <= cmd.override ? override_setpoint : pick(main_sel, pot_r);
         supp_setpoint <= pick(supp_sel, pot_r);
      end
   end

   // read channel, one cycle after address accept
   logic [31:0] rd_val;
   wire [7:0] ra = s_axi_araddr;
   always_comb begin
      rd_val = 32'h00000000;
      case (ra)
         `REG_CTRL: rd_val = ctrl_r;
         `REG_POT_CFG: rd_val = {27'h0, cfg_r};
         `REG_START_VALUE: rd_val = {16'h0, start_r};
         `REG_RAMP_UP: rd_val = up_ms_r;
         `REG_RAMP_DOWN: rd_val = dn_ms_r;
         `REG_MAX_SPEED: rd_val = {16'h0, maxs_r};
         `REG_MIN_SPEED: rd_val = {16'h0, mins_r};
         `REG_SET_VALUE: rd_val = {16'h0, setv_r};
         `REG_POT_OUT: rd_val = {16'h0, pot_r};
         `REG_MAIN_OUT: rd_val = {16'h0, main_setpoint};
         `REG_SUPP_OUT: rd_val = {16'h0, supp_setpoint};
         `REG_STORED: rd_val = {16'h0, stored_r};
         default: rd_val = 32'h00000000;
      endcase
   end
   wire rd_ok = (ra <= `REG_STORED) && (ra[1:0] == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_val;
         rresp_r <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- dv/axi_setpoint_checker.sv
`timescale 1ns/1ps
`default_nettype none
module axi_setpoint_checker (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read response
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic nv_write // store pulse
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   write_resp_a:
      assert property (wr_taken |=> s_axi_bvalid) else $error("no write response");
   read_resp_a:
      assert property (rd_taken |=> s_axi_rvalid) else $error("no read data");
   bresp_release_a:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid kept");
   rresp_release_a:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid kept");
   write_refuse_a:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
         else $error("write taken during response");
   read_refuse_a:
      assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during data");
   unmapped_write_a:
      assert property (wr_taken and s_axi_awaddr > 8'h2C |=> s_axi_bresp == 2'h2)
         else $error("unmapped write not refused");
   unmapped_read_a:
      assert property (rd_taken and s_axi_araddr > 8'h2C |=> s_axi_rresp == 2'h2 &&
         s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   store_pulse_a:
      assert property (nv_write |=> !nv_write) else $error("store pulse too long");
endmodule
bind speed_setpoint_source axi_setpoint_checker axi_setpoint_checker_inst (.aclk, .aresetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nv_write);
`default_nettype wire

//--- dv/src_partner.sv
`timescale 1ns/1ps
`default_nettype none
module src_partner (
   input wire logic aclk, // clock
   input wire logic load, // take new source values
   input wire logic [63:0] vals, // analog, fieldbus, fixed, override
   input wire logic nv_write, // store request
   input wire logic [15:0] nv_value_out, // value to store
   output logic [15:0] analog_in0 = 16'h0000, // analog input 0
   output logic [15:0] fieldbus_pzd2 = 16'h0000, // second process word
   output logic [15:0] fixed_setpoint = 16'h0000, // fixed setpoint
   output logic [15:0] override_setpoint = 16'h0000, // replacement setpoint
   output logic [15:0] nv_value_in = 16'h0000 // nvram content
);
   always @(posedge aclk) begin
      if (load) begin
         {analog_in0, fieldbus_pzd2, fixed_setpoint, override_setpoint} <= vals;
      end
      if (nv_write) begin
         nv_value_in <= nv_value_out;
      end
   end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_defines.svh"
module tb_top;
   localparam logic [31:0] c_on = 32'h1 << `CTRL_MOTOR_ON_BIT;
   localparam logic [31:0] c_up = 32'h1 << `CTRL_RAISE_BIT;
   localparam logic [31:0] c_dn = 32'h1 << `CTRL_LOWER_BIT;
   localparam logic [31:0] c_inv = 32'h1 << `CTRL_INVERT_BIT;
   localparam logic [31:0] c_aut = 32'h1 << `CTRL_AUTO_BIT;
   localparam logic [31:0] c_acc = 32'h1 << `CTRL_ACCEPT_BIT;
   localparam logic [31:0] c_ovr = 32'h1 << `CTRL_OVERRIDE_BIT;
   logic aclk = 1'b0, aresetn = 1'b0, load = 1'b0, nv_write;
   logic [63:0] vals = 64'h0;
   logic [15:0] analog_in0, fieldbus_pzd2, fixed_setpoint, override_setpoint, nv_value_in;
   logic [15:0] nv_value_out, main_setpoint, supp_setpoint, v, rv;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   int n_mismatch = 0, total_checks = 0, cyc = 0, seed = 70899, i, s;
   speed_setpoint_source #(.MS_CYC(1)) speed_setpoint_source_inst (.aclk, .aresetn, .analog_in0,
      .fieldbus_pzd2, .fixed_setpoint, .override_setpoint, .nv_value_in, .nv_write,
      .nv_value_out, .main_setpoint, .supp_setpoint, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   src_partner src_partner_inst (.aclk, .load, .vals, .nv_write, .nv_value_out, .analog_in0,
      .fieldbus_pzd2, .fixed_setpoint, .override_setpoint, .nv_value_in);
   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         conclude();
      end
   end
   task conclude;
      if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw = 1'b1, w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a);
      logic ar = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (ar && s_axi_arready) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata[15:0];
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic potw(input logic [15:0] e, input int lim, input string m);
      int k = 0;
      do begin
         rd(`REG_POT_OUT);
         k++;
      end while (rv !== e && k < lim);
      chk(rv, e, m);
   endtask
   function automatic logic [15:0] pick(input int k);
      case (k)
         0: return vals[63:48];
         1: return vals[47:32];
         2: return vals[31:16];
         default: return v;
      endcase
   endfunction
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`REG_CTRL); chk(rv, 16'h0000, "ctrl");
      rd(`REG_POT_CFG); chk(rv, 16'h0006, "cfg");
      rd(`REG_START_VALUE); chk(rv, 16'h0000, "start");
      rd(`REG_RAMP_UP); chk(rv, 16'h2710, "ramp up");
      rd(`REG_RAMP_DOWN); chk(rv, 16'h2710, "ramp down");
      rd(`REG_MAX_SPEED); chk(rv, 16'h0000, "max");
      rd(`REG_MIN_SPEED); chk(rv, 16'h0000, "min");
      rd(8'h30); chk({14'h0, rr}, 16'h0002, "unmapped read");
      wr(8'h31, 32'h1); chk({14'h0, rr}, 16'h0002, "unaligned write");
      wr(`REG_RAMP_UP, 32'h7FFF);
      wr(`REG_RAMP_DOWN, 32'h7FFF);
      wr(`REG_MAX_SPEED, 32'h03E8);
      wr(`REG_MIN_SPEED, 32'h00C8);
      wr(`REG_START_VALUE, 32'h012C);
      wr(`REG_CTRL, c_on); potw(16'h012C, 5, "switch on");
      wr(`REG_CTRL, c_on | c_up);
      repeat (40) @(posedge aclk);
      wr(`REG_CTRL, c_on | c_up | c_dn);
      rd(`REG_POT_OUT);
      v = rv;
      chk({15'h0, v >= 16'h0148 && v <= 16'h0150}, 16'h0001, "slew");
      repeat (50) @(posedge aclk);
      rd(`REG_POT_OUT); chk(rv, v, "both held");
      wr(`REG_CTRL, c_on | c_up); potw(16'h03E8, 800, "max clamp");
      wr(`REG_CTRL, c_on | c_dn); potw(16'h00C8, 800, "min clamp");
      wr(`REG_CTRL, c_on | c_inv | c_dn); potw(16'hFC18, 1000, "inv low");
      wr(`REG_CTRL, c_on | c_inv | c_up); potw(16'hFF38, 1000, "inv high");
      wr(`REG_SET_VALUE, 32'h01F4);
      wr(`REG_CTRL, c_on);
      wr(`REG_CTRL, c_on | c_acc); potw(16'h01F4, 5, "accept");
      wr(`REG_POT_CFG, 32'h000F);
      wr(`REG_CTRL, 32'h0);
      rd(`REG_STORED); chk(rv, 16'h01F4, "stored");
      chk(nv_value_in, 16'h01F4, "nvram");
      wr(`REG_CTRL, c_on); potw(16'h01F4, 5, "restore");
      wr(`REG_POT_CFG, 32'h0006);
      wr(`REG_CTRL, 32'h0);
      wr(`REG_CTRL, c_on); potw(16'h012C, 5, "no restore");
      wr(`REG_POT_CFG, 32'h0004);
      wr(`REG_CTRL, c_on | c_aut | c_up); potw(16'h03E8, 4, "auto step");
      wr(`REG_CTRL, c_on | c_dn);
      repeat (20) @(posedge aclk);
      rd(`REG_POT_OUT);
      chk({15'h0, rv > 16'h03C0 && rv < 16'h03E8}, 16'h0001, "manual ramp");
      wr(`REG_POT_CFG, 32'h0016);
      wr(`REG_CTRL, c_dn); potw(16'h00C8, 800, "ramp while off");
      wr(`REG_CTRL, c_on); potw(16'h012C, 5, "switch on again");
      repeat (3) begin
         vals <= {$random(seed), $random(seed)};
         load <= 1'b1;
         @(posedge aclk);
         load <= 1'b0;
         @(posedge aclk);
         rd(`REG_POT_OUT);
         v = rv;
         for (s = 0; s < 4; s++) begin
            wr(`REG_CTRL, c_on | 32'(s) | (32'((s + 1) % 4) << 4));
            for (i = 0; i < 20 && main_setpoint !== pick(s); i++) @(posedge aclk);
            chk(main_setpoint, pick(s), "main");
            chk(supp_setpoint, pick((s + 1) % 4), "supp");
         end
         wr(`REG_CTRL, c_on | c_ovr);
         for (i = 0; i < 20 && main_setpoint !== vals[15:0]; i++) @(posedge aclk);
         chk(main_setpoint, vals[15:0], "override");
      end
      conclude();
   end
endmodule
`default_nettype wire
